// >>> psp_bus_model.sv
`default_nettype none

module psp_bus_model
  import psp_pkg::*;
(
  input wire logic [2:0] op,
  input wire logic [PSP_LANES-1:0] lanes_n,
  output var psp_strobe_t strobe,
  output var psp_select_t sel,
  output var psp_write_t wr
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Bus cycle decode
  // ----------------------------------------------------------------
  always_comb begin
    strobe = '{cpu_n: 1'b1, ctrl_n: 1'b1, step_n: 1'b1};
    sel = '{master_n: 1'b0, high: 1'b1, low_n: 1'b0};
    wr = '{global_n: 1'b1, gate_n: 1'b1, lane_n: lanes_n};
    case (op)
      3'h1: strobe = '{cpu_n: 1'b0, ctrl_n: 1'b1, step_n: 1'b0};
      3'h2: strobe.ctrl_n = 1'b0;
      3'h3: begin
        strobe.ctrl_n = 1'b0;
        wr.global_n = 1'b0;
      end
      3'h4: strobe.step_n = 1'b0;
      3'h5: begin
        strobe.step_n = 1'b0;
        wr.gate_n = 1'b0;
      end
      3'h6: begin
        strobe.cpu_n = 1'b0;
        sel.high = 1'b0;
      end
      3'h7: begin
        // Master deselected: processor strobe is blocked, controller strobe still acts
        strobe = '{cpu_n: 1'b0, ctrl_n: 1'b0, step_n: 1'b1};
        sel.master_n = 1'b1;
      end
      default: ;
    endcase
  end
endmodule

`default_nettype wire

// >>> psp_pkg.sv
`default_nettype none

package psp_pkg;

  // ----------------------------------------------------------------
  // Array organisation
  // ----------------------------------------------------------------
  localparam int PSP_ADDR_W = 18;
  localparam int PSP_DEPTH = 262144;
  localparam int PSP_LANES = 4;
  localparam int PSP_LANE_W = 9;
  localparam int PSP_DATA_W = 36;
  localparam int PSP_BURST_W = 2;
  localparam int PSP_BASE_W = PSP_ADDR_W - PSP_BURST_W;

  // ----------------------------------------------------------------
  // Reset values and other constants of the control state
  // ----------------------------------------------------------------
  localparam logic [PSP_BURST_W-1:0] PSP_COUNT_RST = 2'h0;
  localparam logic [PSP_BURST_W-1:0] PSP_COUNT_ONE = 2'h1;
  localparam logic [PSP_BASE_W-1:0] PSP_BASE_RST = 16'h0000;
  localparam logic [PSP_ADDR_W-1:0] PSP_ADDR_RST = 18'h00000;
  localparam logic [PSP_DATA_W-1:0] PSP_DATA_RST = 36'h000000000;
  localparam logic [PSP_LANES-1:0] PSP_LANES_NONE = 4'h0;
  localparam logic [PSP_LANES-1:0] PSP_LANES_ALL = 4'hF;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cpu_n;
    logic ctrl_n;
    logic step_n;
  } psp_strobe_t;

  typedef struct packed {
    logic master_n;
    logic high;
    logic low_n;
  } psp_select_t;

  typedef struct packed {
    logic global_n;
    logic gate_n;
    logic [PSP_LANES-1:0] lane_n;
  } psp_write_t;

  typedef struct packed {
    logic [PSP_BASE_W-1:0] base;
    logic [PSP_BURST_W-1:0] start;
    logic [PSP_BURST_W-1:0] count;
  } psp_burst_t;

  typedef enum {PSP_DESELECTED, PSP_READ, PSP_WRITE} psp_state_t;

  typedef enum {
    PSP_OP_NONE,
    PSP_OP_DESELECT,
    PSP_OP_BEGIN_CPU,
    PSP_OP_BEGIN_CTRL,
    PSP_OP_CONTINUE,
    PSP_OP_SUSPEND
  } psp_op_t;

endpackage

`default_nettype wire

// >>> psp_port_chk.sv
`default_nettype none

module psp_port_chk
  import psp_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [PSP_DATA_W-1:0] DQ_OUT,
  input wire logic DQ_OE,
  input wire logic CPU_ADDR_STROBE_N,
  input wire logic CTRL_ADDR_STROBE_N,
  input wire logic BURST_STEP_N,
  input wire logic GLOBAL_WRITE_N,
  input wire logic [PSP_LANES-1:0] BYTE_LANE_WRITE_N,
  input wire logic MASTER_SELECT_N,
  input wire logic SELECT_HIGH,
  input wire logic SELECT_LOW_N,
  input wire logic OUTPUT_ENABLE_N,
  input wire logic FLOW_THROUGH_SELECT_N,
  input wire logic SNOOZE_INPUT,
  input wire logic STANDBY,
  input wire logic LOW_POWER
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------
  logic sel_ok;
  logic cpu_go;
  logic hold;
  logic ena;
  assign sel_ok = SELECT_HIGH && !SELECT_LOW_N;
  assign cpu_go = !SNOOZE_INPUT && !CPU_ADDR_STROBE_N && !MASTER_SELECT_N;
  assign hold = !SNOOZE_INPUT && CPU_ADDR_STROBE_N && CTRL_ADDR_STROBE_N && BURST_STEP_N
    && GLOBAL_WRITE_N && (&BYTE_LANE_WRITE_N) && !STANDBY;
  // Output enable may rise between edges, so it excuses a dark bus
  assign ena = OUTPUT_ENABLE_N || SNOOZE_INPUT || DQ_OE;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  AST_LOW_POWER: assert property (LOW_POWER == SNOOZE_INPUT)
    else $error("low power flag differs from snooze");
  AST_FLOAT: assert property ((OUTPUT_ENABLE_N || SNOOZE_INPUT) |-> !DQ_OE)
    else $error("data driven while disabled");
  AST_FREEZE: assert property (SNOOZE_INPUT |=> $stable(STANDBY))
    else $error("state moved during snooze");
  AST_LANE_OFF: assert property (!SNOOZE_INPUT && !(&BYTE_LANE_WRITE_N) |=> !DQ_OE)
    else $error("data driven after lane write");
  AST_CPU_DESEL: assert property (cpu_go && !sel_ok |=> STANDBY)
    else $error("no standby after deselect");
  AST_CPU_START: assert property (cpu_go && sel_ok |=> !STANDBY)
    else $error("read not begun");
  AST_CTRL_DESEL: assert property (!SNOOZE_INPUT && !CTRL_ADDR_STROBE_N && !cpu_go
    && (MASTER_SELECT_N || !sel_ok) |=> STANDBY)
    else $error("controller strobe did not deselect");
  // A write turning into a read reloads the output once, so require a driven read first
  AST_HOLD_DQ: assert property ((hold ##1 (hold && DQ_OE)) |=> $stable(DQ_OUT))
    else $error("data moved while suspended");
  AST_PIPE_OE: assert property ((FLOW_THROUGH_SELECT_N && cpu_go && sel_ok) ##1
    (hold && !OUTPUT_ENABLE_N) |=> ena)
    else $error("pipelined read data not driven");
  AST_FLOW_OE: assert property (!FLOW_THROUGH_SELECT_N && cpu_go && sel_ok
    && GLOBAL_WRITE_N && (&BYTE_LANE_WRITE_N) |=> ena)
    else $error("flow-through data late");
  COV_READ: cover property ((cpu_go && sel_ok) ##2 DQ_OE);
  COV_LANE: cover property (!GLOBAL_WRITE_N ##1 !(&BYTE_LANE_WRITE_N));
  COV_SNOOZE: cover property (SNOOZE_INPUT ##1 !SNOOZE_INPUT);
endmodule

bind psp_sram_port psp_port_chk u_psp_port_chk (.CLK(CLK), .RESET_N(RESET_N),
  .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .CPU_ADDR_STROBE_N(CPU_ADDR_STROBE_N),
  .CTRL_ADDR_STROBE_N(CTRL_ADDR_STROBE_N), .BURST_STEP_N(BURST_STEP_N),
  .GLOBAL_WRITE_N(GLOBAL_WRITE_N), .BYTE_LANE_WRITE_N(BYTE_LANE_WRITE_N),
  .MASTER_SELECT_N(MASTER_SELECT_N), .SELECT_HIGH(SELECT_HIGH), .SELECT_LOW_N(SELECT_LOW_N),
  .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .FLOW_THROUGH_SELECT_N(FLOW_THROUGH_SELECT_N),
  .SNOOZE_INPUT(SNOOZE_INPUT), .STANDBY(STANDBY), .LOW_POWER(LOW_POWER));

`default_nettype wire

// >>> psp_sram_port.sv
`default_nettype none

// Functional notes
// - All synchronous inputs sampled on rising clock; enable, mode and snooze pins are not.
// - Pipelined read: address registered, word loaded to output register, driven next edge.
// - Processor strobe low with selects active loads address and begins a read.
// - Burst step ignored on the processor strobe edge, sampled on later edges.
// - Read burst advances when step low and both strobes sampled high.
// - Burst order select high: low address bits are start XOR step count.
// - Burst order select low: low address bits count linearly modulo four.
// - Global write low writes every byte lane regardless of lane inputs.
// - Global write high: only lanes low while byte write gate is low are written.
// - Gate high or no lane active with global write high makes a read cycle.
// - Lane write inputs write nothing on processor strobe edge but still block the drivers; sampled on later edges.
// - Any lane write sampled low turns off the data drivers despite output enable.
// - Data pins captured into the input data register on every edge that writes (mem_we).
// - Write burst advances when a lane write and burst step are sampled low.
// - Controller strobe cycles sample write enables on the strobe edge itself.
// - Master select gates only the processor strobe; controller strobe still deselects.
// - Secondary selects sampled with controller strobe, or master and processor strobe.
// - Address sampled only when all selects active and an address strobe asserted.
// - Strobe with selects inactive deselects into standby; data pins float, one edge later when pipelined.
// - Data pins driven only with output enable low during a read cycle.
// - Flow-through select low bypasses the output register; high runs pipelined.
// - Snooze asserted enters low power and keeps all stored contents.

module psp_sram_port
  import psp_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [PSP_ADDR_W-1:0] ADDRESS_INPUTS,
  input wire logic [PSP_DATA_W-1:0] DQ_IN,
  output logic [PSP_DATA_W-1:0] DQ_OUT,
  output logic DQ_OE,
  input wire logic CPU_ADDR_STROBE_N,
  input wire logic CTRL_ADDR_STROBE_N,
  input wire logic BURST_STEP_N,
  input wire logic GLOBAL_WRITE_N,
  input wire logic BYTE_WRITE_GATE_N,
  input wire logic [PSP_LANES-1:0] BYTE_LANE_WRITE_N,
  input wire logic MASTER_SELECT_N,
  input wire logic SELECT_HIGH,
  input wire logic SELECT_LOW_N,
  input wire logic OUTPUT_ENABLE_N,
  input wire logic FLOW_THROUGH_SELECT_N,
  input wire logic BURST_ORDER_SELECT_N,
  input wire logic SNOOZE_INPUT,
  output logic STANDBY,
  output logic LOW_POWER
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [PSP_DATA_W-1:0] mem [PSP_DEPTH];

  psp_strobe_t strobe;
  psp_select_t sel;
  psp_write_t wr;
  psp_burst_t burst;
  psp_state_t state;
  psp_state_t next_state;
  psp_op_t op;

  logic cpu_live;
  logic sel_all;
  logic active;
  logic starting;
  logic [PSP_LANES-1:0] lane_we;
  logic mem_we;
  logic [PSP_BURST_W-1:0] burst_low;
  logic [PSP_BURST_W-1:0] next_count;
  logic [PSP_BURST_W-1:0] next_low;
  logic [PSP_ADDR_W-1:0] cur_addr;
  logic [PSP_ADDR_W-1:0] wr_target;

  logic [PSP_DATA_W-1:0] din_reg;
  logic [PSP_LANES-1:0] din_lanes;
  logic [PSP_ADDR_W-1:0] din_addr;
  logic din_pend;

  logic [PSP_DATA_W-1:0] array_word;
  logic [PSP_DATA_W-1:0] rd_word;
  logic [PSP_DATA_W-1:0] out_reg;
  logic out_valid;
  logic drive_block;
  logic flow_mode;
  logic read_phase;

  // ----------------------------------------------------------------
  // Input grouping
  // ----------------------------------------------------------------
  assign strobe = '{cpu_n: CPU_ADDR_STROBE_N, ctrl_n: CTRL_ADDR_STROBE_N,
                    step_n: BURST_STEP_N};
  assign sel = '{master_n: MASTER_SELECT_N, high: SELECT_HIGH, low_n: SELECT_LOW_N};
  assign wr = '{global_n: GLOBAL_WRITE_N, gate_n: BYTE_WRITE_GATE_N,
                lane_n: BYTE_LANE_WRITE_N};

  // Mode pins are static straps and are used directly, never registered
  assign flow_mode = !FLOW_THROUGH_SELECT_N;

  // ----------------------------------------------------------------
  // Cycle decode
  // ----------------------------------------------------------------
  // The master select masks the processor strobe before anything else sees it
  assign cpu_live = !strobe.cpu_n && !sel.master_n;
  assign sel_all = !sel.master_n && sel.high && !sel.low_n;
  assign active = (state != PSP_DESELECTED);

  always_comb begin
    op = PSP_OP_NONE;
    if (SNOOZE_INPUT) begin
      op = PSP_OP_NONE;
    end else if (cpu_live) begin
      // Processor strobe wins over write enables and controller strobe
      op = sel_all ? PSP_OP_BEGIN_CPU : PSP_OP_DESELECT;
    end else if (!strobe.ctrl_n) begin
      // A blocked processor strobe counts as high here
      op = sel_all ? PSP_OP_BEGIN_CTRL : PSP_OP_DESELECT;
    end else if (!strobe.step_n) begin
      op = PSP_OP_CONTINUE;
    end else begin
      op = PSP_OP_SUSPEND;
    end
  end

  assign starting = (op == PSP_OP_BEGIN_CPU) || (op == PSP_OP_BEGIN_CTRL);

  // ----------------------------------------------------------------
  // Write enable decode
  // ----------------------------------------------------------------
  always_comb begin
    lane_we = PSP_LANES_NONE;
    if (!wr.global_n) begin
      lane_we = PSP_LANES_ALL;
    end else if (!wr.gate_n) begin
      lane_we = ~wr.lane_n;
    end else begin
      lane_we = PSP_LANES_NONE;
    end
    // Write inputs enable no lane on the processor strobe edge; lane inputs still set the driver block
    if (op == PSP_OP_BEGIN_CPU || op == PSP_OP_NONE || op == PSP_OP_DESELECT) begin
      lane_we = PSP_LANES_NONE;
    end
  end

  // Controller strobe edges may write at once; bursts write only while selected
  always_comb begin
    mem_we = 1'b0;
    unique case (op)
      PSP_OP_BEGIN_CTRL: mem_we = |lane_we;
      PSP_OP_CONTINUE,
      PSP_OP_SUSPEND: mem_we = active && (|lane_we);
      PSP_OP_NONE,
      PSP_OP_DESELECT,
      PSP_OP_BEGIN_CPU: mem_we = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Burst address
  // ----------------------------------------------------------------
  always_comb begin
    if (BURST_ORDER_SELECT_N) begin
      burst_low = burst.start ^ burst.count;
    end else begin
      burst_low = burst.start + burst.count;
    end
  end

  assign cur_addr = {burst.base, burst_low};

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      burst.base <= PSP_BASE_RST;
      burst.start <= PSP_COUNT_RST;
      burst.count <= PSP_COUNT_RST;
    end else if (starting) begin
      burst.base <= ADDRESS_INPUTS[PSP_ADDR_W-1:PSP_BURST_W];
      burst.start <= ADDRESS_INPUTS[PSP_BURST_W-1:0];
      burst.count <= PSP_COUNT_RST;
    end else if (op == PSP_OP_CONTINUE && active) begin
      // Counter wraps within the four-word block, as both orders require
      burst.count <= burst.count + PSP_COUNT_ONE;
    end
  end

  // ----------------------------------------------------------------
  // Write address
  // ----------------------------------------------------------------
  // A continue edge writes the word it steps to, so the write target runs
  // one count ahead of the address the read path is using
  assign next_count = burst.count + PSP_COUNT_ONE;

  always_comb begin
    if (BURST_ORDER_SELECT_N) begin
      next_low = burst.start ^ next_count;
    end else begin
      next_low = burst.start + next_count;
    end
  end

  always_comb begin
    wr_target = cur_addr;
    unique case (op)
      // Address pins only matter on a start edge with every select active
      PSP_OP_BEGIN_CTRL: wr_target = ADDRESS_INPUTS;
      PSP_OP_CONTINUE: wr_target = {burst.base, next_low};
      PSP_OP_SUSPEND: wr_target = cur_addr;
      PSP_OP_NONE,
      PSP_OP_DESELECT,
      PSP_OP_BEGIN_CPU: wr_target = cur_addr;
    endcase
  end

  // ----------------------------------------------------------------
  // Cycle state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (op)
      PSP_OP_DESELECT: next_state = PSP_DESELECTED;
      PSP_OP_BEGIN_CPU: next_state = PSP_READ;
      PSP_OP_BEGIN_CTRL: next_state = (|lane_we) ? PSP_WRITE : PSP_READ;
      PSP_OP_CONTINUE,
      PSP_OP_SUSPEND: begin
        if (active) begin
          next_state = (|lane_we) ? PSP_WRITE : PSP_READ;
        end
      end
      PSP_OP_NONE: next_state = state;
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= PSP_DESELECTED;
    end else begin
      state <= next_state;
    end
  end

  assign STANDBY = (state == PSP_DESELECTED);
  assign LOW_POWER = SNOOZE_INPUT;

  // ----------------------------------------------------------------
  // Input data register
  // ----------------------------------------------------------------
  // Writes are committed one edge late so the array sees a registered word;
  // the read path below forwards the pending word to hide that delay.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      din_reg <= PSP_DATA_RST;
      din_lanes <= PSP_LANES_NONE;
      din_addr <= PSP_ADDR_RST;
      din_pend <= 1'b0;
    end else begin
      din_pend <= mem_we;
      if (mem_we) begin
        din_reg <= DQ_IN;
        din_lanes <= lane_we;
        din_addr <= wr_target;
      end
    end
  end

  // Array has no reset, matching a memory that keeps contents through snooze
  always_ff @(posedge CLK) begin
    if (din_pend) begin
      for (int l = 0; l < PSP_LANES; l++) begin
        if (din_lanes[l]) begin
          mem[din_addr][l*PSP_LANE_W +: PSP_LANE_W] <= din_reg[l*PSP_LANE_W +: PSP_LANE_W];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  assign array_word = mem[cur_addr];

  // One process owns the whole word; the pending write overrides lane by lane
  always_comb begin
    rd_word = array_word;
    for (int l = 0; l < PSP_LANES; l++) begin
      if (din_pend && din_lanes[l] && (din_addr == cur_addr)) begin
        rd_word[l*PSP_LANE_W +: PSP_LANE_W] = din_reg[l*PSP_LANE_W +: PSP_LANE_W];
      end
    end
  end

  // Output register follows the address registered one edge earlier
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      out_reg <= PSP_DATA_RST;
      out_valid <= 1'b0;
    end else if (!SNOOZE_INPUT) begin
      out_valid <= (state == PSP_READ);
      if (state == PSP_READ) begin
        out_reg <= rd_word;
      end
    end
  end

  // Flow-through trades a longer clock-to-data path for one cycle less latency
  assign DQ_OUT = flow_mode ? rd_word : out_reg;

  // ----------------------------------------------------------------
  // Output drivers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      drive_block <= 1'b0;
    end else if (!SNOOZE_INPUT) begin
      drive_block <= !(&wr.lane_n) || (mem_we && !wr.global_n);
    end
  end

  assign read_phase = flow_mode ? (state == PSP_READ) : out_valid;

  // Output enable and snooze act without the clock; read phase and driver block are registered
  assign DQ_OE = !OUTPUT_ENABLE_N && read_phase && !drive_block
                 && !SNOOZE_INPUT;

endmodule

`default_nettype wire

// >>> test_pipelined_burst_sram_port.sv
`default_nettype none

module test_pipelined_burst_sram_port;
  timeunit 1ns;
  timeprecision 1ns;
  import psp_pkg::*;
  typedef struct packed {
    logic [2:0] op;
    logic lin;
    logic [1:0] lo;
    logic [3:0] ln;
    logic [35:0] din;
    logic ck;
    logic oe;
    logic sb;
    logic [35:0] dq;
  } psp_row_t;
  localparam logic [35:0] D0 = 36'h111111111;
  localparam logic [35:0] D1 = 36'h222222222;
  localparam logic [35:0] D2 = 36'h333333333;
  localparam logic [35:0] D3 = 36'h444444444;
  localparam logic [35:0] DL = 36'h000000055;
  localparam logic [35:0] DM = 36'h111111055;
  localparam logic [35:0] DJ = 36'hFFFFFFFFF;
  localparam psp_row_t rows [23] = '{
    '{3'h3, 1'b0, 2'h1, 4'hF, D0, 1'b1, 1'b0, 1'b0, D0},
    '{3'h5, 1'b0, 2'h0, 4'h0, D1, 1'b1, 1'b0, 1'b0, D0},
    '{3'h5, 1'b0, 2'h0, 4'h0, D2, 1'b1, 1'b0, 1'b0, D0},
    '{3'h5, 1'b0, 2'h0, 4'h0, D3, 1'b1, 1'b0, 1'b0, D0},
    '{3'h5, 1'b0, 2'h0, 4'hE, DL, 1'b1, 1'b0, 1'b0, D0},
    '{3'h1, 1'b0, 2'h1, 4'h0, DJ, 1'b1, 1'b0, 1'b0, D0},
    '{3'h0, 1'b0, 2'h0, 4'hF, DJ, 1'b1, 1'b1, 1'b0, DM},
    '{3'h4, 1'b0, 2'h0, 4'hF, DJ, 1'b1, 1'b1, 1'b0, DM},
    '{3'h4, 1'b0, 2'h0, 4'hF, DJ, 1'b1, 1'b1, 1'b0, D1},
    '{3'h4, 1'b0, 2'h0, 4'hF, DJ, 1'b1, 1'b1, 1'b0, D2},
    '{3'h0, 1'b0, 2'h0, 4'hF, DJ, 1'b1, 1'b1, 1'b0, D3},
    '{3'h0, 1'b0, 2'h0, 4'hF, DJ, 1'b1, 1'b1, 1'b0, D3},
    '{3'h1, 1'b1, 2'h1, 4'hF, DJ, 1'b0, 1'b0, 1'b0, D0},
    '{3'h4, 1'b1, 2'h2, 4'hF, DJ, 1'b1, 1'b1, 1'b0, DM},
    '{3'h4, 1'b1, 2'h0, 4'hF, DJ, 1'b1, 1'b1, 1'b0, D3},
    '{3'h4, 1'b1, 2'h0, 4'hF, DJ, 1'b1, 1'b1, 1'b0, D2},
    '{3'h0, 1'b1, 2'h0, 4'hF, DJ, 1'b1, 1'b1, 1'b0, D1},
    '{3'h6, 1'b0, 2'h0, 4'hF, DJ, 1'b0, 1'b0, 1'b1, D0},
    '{3'h0, 1'b0, 2'h0, 4'hF, DJ, 1'b1, 1'b0, 1'b1, D0},
    '{3'h2, 1'b0, 2'h3, 4'hF, DJ, 1'b1, 1'b0, 1'b0, D0},
    '{3'h0, 1'b0, 2'h0, 4'hF, DJ, 1'b1, 1'b1, 1'b0, D2},
    '{3'h7, 1'b0, 2'h0, 4'hF, DJ, 1'b0, 1'b0, 1'b1, D0},
    '{3'h0, 1'b0, 2'h0, 4'hF, DJ, 1'b1, 1'b0, 1'b1, D0}
  };
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] op = 3'h0;
  logic [3:0] lanes = 4'hF;
  logic [17:0] addr = 18'h00000;
  logic [35:0] din = 36'h000000000;
  logic lbo_n = 1'b1;
  logic ft_n = 1'b1;
  logic oe_n = 1'b0;
  logic zz = 1'b0;
  logic ft_s = 1'b1;
  logic oe_s = 1'b0;
  logic zz_s = 1'b0;
  logic [35:0] dq_out;
  logic dq_oe;
  logic standby;
  logic low_power;
  psp_strobe_t strobe;
  psp_select_t sel;
  psp_write_t wr;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  always #50 clk = ~clk;
  psp_bus_model u_psp_bus_model (.op(op), .lanes_n(lanes), .strobe(strobe), .sel(sel), .wr(wr));
  psp_sram_port u_psp_sram_port (.CLK(clk), .RESET_N(rst_n), .ADDRESS_INPUTS(addr),
    .DQ_IN(din), .DQ_OUT(dq_out), .DQ_OE(dq_oe), .CPU_ADDR_STROBE_N(strobe.cpu_n),
    .CTRL_ADDR_STROBE_N(strobe.ctrl_n), .BURST_STEP_N(strobe.step_n),
    .GLOBAL_WRITE_N(wr.global_n), .BYTE_WRITE_GATE_N(wr.gate_n), .BYTE_LANE_WRITE_N(wr.lane_n),
    .MASTER_SELECT_N(sel.master_n), .SELECT_HIGH(sel.high), .SELECT_LOW_N(sel.low_n),
    .OUTPUT_ENABLE_N(oe_n), .FLOW_THROUGH_SELECT_N(ft_n), .BURST_ORDER_SELECT_N(lbo_n),
    .SNOOZE_INPUT(zz), .STANDBY(standby), .LOW_POWER(low_power));
  task automatic wrap_up();
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Outputs seen after this call reflect the edge that sampled the previous call
  task automatic cyc(input logic [2:0] o, input logic l, input logic [1:0] a,
      input logic [3:0] ln, input logic [35:0] d);
    @(posedge clk);
    op <= o;
    lbo_n <= ~l;
    addr <= {16'h0040, a};
    lanes <= ln;
    din <= d;
    ft_n <= ft_s;
    oe_n <= oe_s;
    zz <= zz_s;
    @(negedge clk);
  endtask
  task automatic check(input psp_row_t r);
    cmp(standby, r.sb);
    if (r.ck) begin
      cmp(dq_oe, r.oe);
      if (r.oe) cmp(dq_out, r.dq);
    end
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 300) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 23; i++) begin
      cyc(rows[i].op, rows[i].lin, rows[i].lo, rows[i].ln, rows[i].din);
      if (i > 0) check(rows[i-1]);
    end
    ft_s = 1'b0;
    cyc(3'h0, 1'b0, 2'h0, 4'hF, DJ);
    check(rows[22]);
    cyc(3'h1, 1'b0, 2'h0, 4'hF, DJ);
    cyc(3'h0, 1'b0, 2'h0, 4'hF, DJ);
    cmp(dq_oe, 1'b1);
    cmp(dq_out, D1);
    oe_s = 1'b1;
    cyc(3'h0, 1'b0, 2'h0, 4'hF, DJ);
    cmp(dq_oe, 1'b0);
    oe_s = 1'b0;
    zz_s = 1'b1;
    cyc(3'h4, 1'b0, 2'h0, 4'hF, DJ);
    cmp(low_power, 1'b1);
    cmp(dq_oe, 1'b0);
    cyc(3'h4, 1'b0, 2'h0, 4'hF, DJ);
    zz_s = 1'b0;
    cyc(3'h0, 1'b0, 2'h0, 4'hF, DJ);
    cmp(dq_out, D1);
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    cmp(standby, 1'b1);
    cmp(dq_oe, 1'b0);
    wrap_up();
  end
endmodule

`default_nettype wire
